// >>> hw/fsu_top.sv
// Instruction fetch sampling unit: interval counter, tagging and capture
`timescale 1ns/100ps
module fsu_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_sel,
   input wire logic [63:0] reg_wdata,
   output logic [63:0] reg_rdata,
   output logic reg_rvalid,
   // Fetch pipeline events
   input wire logic fetch_start,
   input wire logic fetch_done,
   input wire logic fetch_abort,
   input wire logic fetch_icache_miss,
   input wire logic fetch_tlb_miss,
   input wire logic fetch_phys_ok,
   input wire logic [1:0] fetch_page_size,
   input wire logic [63:0] fetch_lin_addr,
   input wire logic [fsu_pkg::FSU_PHYS_W-1:0] fetch_phys_addr,
   // Sampler outputs
   output logic tag_request,
   output logic sample_irq
);
   import fsu_pkg::*;

   fsu_lat_if lat_bus ();
   logic [3:0] rand_nibble;

   // Control register fields
   logic en_reg, en_next;
   logic valid_reg, valid_next;
   logic rand_en_reg, rand_en_next;
   logic tlb_miss_reg, tlb_miss_next;
   logic [1:0] pgsz_reg, pgsz_next;
   logic pav_reg, pav_next;
   logic icmiss_reg, icmiss_next;
   logic comp_reg, comp_next;
   logic [FSU_LAT_W-1:0] lat_reg, lat_next;
   logic [15:0] max_reg, max_next;
   logic [FSU_CNT_W-1:0] cnt_reg, cnt_next;
   logic [63:0] lin_reg, lin_next;
   logic [FSU_PHYS_W-1:0] phys_reg, phys_next;
   fsu_state_e state_reg, state_next;
   logic irq_reg, irq_next;
   logic [63:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;

   // Helper terms
   logic armed;
   logic match;
   logic capture;
   logic [63:0] ctrl_word;

   // Latency timer for the tagged fetch
   fsu_latency #(.LAT_W(FSU_LAT_W)) u_latency (
      .clock(clock),
      .rst_n(rst_n),
      .lat(lat_bus)
   );

   // Free-running source, so the low-bit offset is hard to predict
   fsu_lfsr #(.LFSR_W(FSU_LFSR_W)) u_lfsr (
      .clock(clock),
      .rst_n(rst_n),
      .rand_nibble(rand_nibble)
   );

   assign armed = en_reg && !valid_reg;
   assign match = cnt_reg[FSU_CNT_W-1:4] == max_reg;
   assign capture = (state_reg == FSU_ST_BUSY) && en_reg && (fetch_done || fetch_abort);

   // Timer runs from the tagged fetch's start to its end
   assign lat_bus.start = (state_reg == FSU_ST_PEND) && armed && fetch_start;
   assign lat_bus.stop = capture || (state_reg == FSU_ST_BUSY && !en_reg);

   // Read view of the control word; reserved bits stay zero
   always_comb begin
      ctrl_word = '0;
      ctrl_word[FSU_RAND_BIT] = rand_en_reg;
      ctrl_word[FSU_TLBMISS_BIT] = tlb_miss_reg;
      ctrl_word[FSU_PGSZ_HI:FSU_PGSZ_LO] = pgsz_reg;
      ctrl_word[FSU_PAV_BIT] = pav_reg;
      ctrl_word[FSU_ICMISS_BIT] = icmiss_reg;
      ctrl_word[FSU_COMP_BIT] = comp_reg;
      ctrl_word[FSU_VALID_BIT] = valid_reg;
      ctrl_word[FSU_EN_BIT] = en_reg;
      ctrl_word[FSU_LAT_HI:FSU_LAT_LO] = lat_reg;
      ctrl_word[FSU_CNT_HI:FSU_CNT_LO] = cnt_reg[FSU_CNT_W-1:4];
      ctrl_word[FSU_MAX_HI:FSU_MAX_LO] = max_reg;
   end

   // Sampler sequence, software writes, capture; capture wins over a write
   always_comb begin
      en_next = en_reg;
      valid_next = valid_reg;
      rand_en_next = rand_en_reg;
      tlb_miss_next = tlb_miss_reg;
      pgsz_next = pgsz_reg;
      pav_next = pav_reg;
      icmiss_next = icmiss_reg;
      comp_next = comp_reg;
      lat_next = lat_reg;
      max_next = max_reg;
      cnt_next = cnt_reg;
      lin_next = lin_reg;
      phys_next = phys_reg;
      state_next = state_reg;
      irq_next = 1'b0;
      // Off, counting, tag pending, tagged fetch in flight
      case (state_reg)
         FSU_ST_OFF: begin
            if (armed) state_next = FSU_ST_COUNT;
         end
         FSU_ST_COUNT: begin
            if (!armed) state_next = FSU_ST_OFF;
            else if (match) state_next = FSU_ST_PEND;
            else if (fetch_done) cnt_next = cnt_reg + 1'b1;
         end
         FSU_ST_PEND: begin
            if (!armed) state_next = FSU_ST_OFF;
            else if (fetch_start) state_next = FSU_ST_BUSY;
         end
         FSU_ST_BUSY: begin
            if (!en_reg) state_next = FSU_ST_OFF;
            else if (capture) state_next = FSU_ST_OFF;
         end
         default: state_next = FSU_ST_OFF;
      endcase
      // Software write; reserved bits are dropped
      if (reg_wr && reg_sel == FSU_SEL_CTRL) begin
         rand_en_next = reg_wdata[FSU_RAND_BIT];
         tlb_miss_next = reg_wdata[FSU_TLBMISS_BIT];
         pgsz_next = reg_wdata[FSU_PGSZ_HI:FSU_PGSZ_LO];
         pav_next = reg_wdata[FSU_PAV_BIT];
         icmiss_next = reg_wdata[FSU_ICMISS_BIT];
         comp_next = reg_wdata[FSU_COMP_BIT];
         valid_next = reg_wdata[FSU_VALID_BIT];
         en_next = reg_wdata[FSU_EN_BIT];
         lat_next = reg_wdata[FSU_LAT_HI:FSU_LAT_LO];
         max_next = reg_wdata[FSU_MAX_HI:FSU_MAX_LO];
         cnt_next[FSU_CNT_W-1:4] = reg_wdata[FSU_CNT_HI:FSU_CNT_LO];
         cnt_next[3:0] = reg_wdata[FSU_RAND_BIT] ? rand_nibble : 4'h0;
         if (state_reg != FSU_ST_BUSY || !reg_wdata[FSU_EN_BIT]) state_next = FSU_ST_OFF;
      end
      // Tagged fetch ends: the hardware set beats a same-cycle clear
      if (capture) begin
         valid_next = 1'b1;
         irq_next = 1'b1;
         comp_next = fetch_done;
         icmiss_next = fetch_icache_miss;
         tlb_miss_next = fetch_tlb_miss;
         pav_next = fetch_phys_ok;
         pgsz_next = fetch_phys_ok ? fetch_page_size : 2'h0;
         lat_next = lat_bus.count;
         lin_next = fetch_lin_addr;
         phys_next = fetch_phys_addr;
         en_next = en_reg;
         state_next = FSU_ST_OFF;
      end
   end

   // Registered read answer, one cycle after the read strobe
   always_comb begin
      rdata_next = rdata_reg;
      rvalid_next = reg_rd;
      if (reg_rd) begin
         case (reg_sel)
            FSU_SEL_CTRL: rdata_next = ctrl_word;
            FSU_SEL_LIN: rdata_next = lin_reg;
            FSU_SEL_PHYS: rdata_next = {{(64 - FSU_PHYS_W){1'b0}}, phys_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   // State registers; reset leaves sampling disabled
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_reg <= 1'b0;
         valid_reg <= 1'b0;
         rand_en_reg <= 1'b0;
         tlb_miss_reg <= 1'b0;
         pgsz_reg <= 2'h0;
         pav_reg <= 1'b0;
         icmiss_reg <= 1'b0;
         comp_reg <= 1'b0;
         lat_reg <= '0;
         max_reg <= 16'h0000;
         cnt_reg <= '0;
         lin_reg <= 64'h0000000000000000;
         phys_reg <= '0;
         state_reg <= FSU_ST_OFF;
         irq_reg <= 1'b0;
         rdata_reg <= 64'h0000000000000000;
         rvalid_reg <= 1'b0;
      end else begin
         en_reg <= en_next;
         valid_reg <= valid_next;
         rand_en_reg <= rand_en_next;
         tlb_miss_reg <= tlb_miss_next;
         pgsz_reg <= pgsz_next;
         pav_reg <= pav_next;
         icmiss_reg <= icmiss_next;
         comp_reg <= comp_next;
         lat_reg <= lat_next;
         max_reg <= max_next;
         cnt_reg <= cnt_next;
         lin_reg <= lin_next;
         phys_reg <= phys_next;
         state_reg <= state_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign tag_request = state_reg[2];
   assign sample_irq = irq_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Write strobe for the one writable register
   logic ctrl_wr;
   assign ctrl_wr = reg_wr && reg_sel == FSU_SEL_CTRL;

   // Register port checks
   a_read_answer: assert property (reg_rvalid == $past(reg_rd))
      else $error("read answer not one cycle after strobe");
   a_load_count: assert property (ctrl_wr && !capture
      |=> cnt_reg[FSU_CNT_W-1:4] == $past(reg_wdata[FSU_CNT_HI:FSU_CNT_LO]))
      else $error("count field not loaded");
   a_rand_zero: assert property (ctrl_wr && !capture && !reg_wdata[FSU_RAND_BIT]
      |=> cnt_reg[3:0] == 4'h0) else $error("low bits not cleared");
   a_reserved_zero: assert property (reg_rd && reg_sel == FSU_SEL_CTRL
      |=> reg_rdata[63:FSU_RAND_BIT+1] == '0 && !reg_rdata[FSU_RAND_BIT-1])
      else $error("reserved control bits not zero");
   a_phys_upper: assert property (reg_rd && reg_sel == FSU_SEL_PHYS
      |=> reg_rdata[63:FSU_PHYS_W] == '0) else $error("physical address upper bits not zero");

   // Sampler sequence checks
   a_count_step: assert property (state_reg == FSU_ST_COUNT && armed && !match && fetch_done && !ctrl_wr
      |=> cnt_reg == $past(cnt_reg) + 1'b1) else $error("counter missed a fetch");
   a_count_gate: assert property (state_reg != FSU_ST_COUNT && !ctrl_wr |=> $stable(cnt_reg))
      else $error("counter moved outside counting");
   a_hold_off: assert property (!armed && !ctrl_wr |=> $stable(cnt_reg))
      else $error("counter moved while off");
   a_match_tags: assert property (state_reg == FSU_ST_COUNT && armed && match && !ctrl_wr
      |=> tag_request ##1 (tag_request || state_reg == FSU_ST_BUSY || !armed || $past(ctrl_wr)))
      else $error("match did not tag");
   a_busy_entry: assert property (state_reg == FSU_ST_BUSY
      |-> $past(state_reg == FSU_ST_PEND || state_reg == FSU_ST_BUSY)) else $error("tagged fetch without a tag");
   a_tag_cancel: assert property (ctrl_wr && !reg_wdata[FSU_EN_BIT] && !capture
      |=> !tag_request && state_reg == FSU_ST_OFF) else $error("disable did not cancel the tag");

   // Capture checks
   a_capture_addr: assert property (capture
      |=> lin_reg == $past(fetch_lin_addr) && phys_reg == $past(fetch_phys_addr))
      else $error("addresses not captured");
   a_status_capture: assert property (capture
      |=> tlb_miss_reg == $past(fetch_tlb_miss) && icmiss_reg == $past(fetch_icache_miss))
      else $error("miss flags not captured");
   a_valid_irq: assert property (capture
      |=> valid_reg && sample_irq && state_reg == FSU_ST_OFF ##1 !sample_irq)
      else $error("valid or interrupt wrong");
   a_irq_source: assert property (sample_irq |-> $past(capture))
      else $error("interrupt without a capture");
   a_valid_holds: assert property (valid_reg && !ctrl_wr |=> valid_reg)
      else $error("valid flag dropped by itself");
   a_comp_done: assert property (capture && fetch_done |=> comp_reg)
      else $error("completion not reported");
   a_comp_abort: assert property (capture && !fetch_done |=> !comp_reg && valid_reg)
      else $error("abort reported complete");
   a_pgsz_gate: assert property (capture && !fetch_phys_ok |=> !pav_reg && pgsz_reg == 2'h0)
      else $error("page size without valid address");
   a_latency_one: assert property (lat_bus.start ##1 capture |=> lat_reg == FSU_LAT_W'(1))
      else $error("one-cycle fetch latency wrong");
endmodule

// >>> hw/fsu_pkg.sv
// Shared constants for the fetch sampling unit
package fsu_pkg;
   // Register select codes on the register port
   localparam logic [1:0] FSU_SEL_CTRL = 2'h0;
   localparam logic [1:0] FSU_SEL_LIN = 2'h1;
   localparam logic [1:0] FSU_SEL_PHYS = 2'h2;

   // Control register field positions
   localparam int FSU_RAND_BIT = 57;
   localparam int FSU_TLBMISS_BIT = 55;
   localparam int FSU_PGSZ_HI = 54;
   localparam int FSU_PGSZ_LO = 53;
   localparam int FSU_PAV_BIT = 52;
   localparam int FSU_ICMISS_BIT = 51;
   localparam int FSU_COMP_BIT = 50;
   localparam int FSU_VALID_BIT = 49;
   localparam int FSU_EN_BIT = 48;
   localparam int FSU_LAT_HI = 47;
   localparam int FSU_LAT_LO = 32;
   localparam int FSU_CNT_HI = 31;
   localparam int FSU_CNT_LO = 16;
   localparam int FSU_MAX_HI = 15;
   localparam int FSU_MAX_LO = 0;

   // Widths and reset values
   localparam int FSU_CNT_W = 20;
   localparam int FSU_LAT_W = 16;
   localparam int FSU_PHYS_W = 52;
   localparam int FSU_LFSR_W = 16;
   localparam logic [15:0] FSU_LFSR_SEED = 16'hACE1;
   localparam logic [15:0] FSU_LFSR_TAPS = 16'hB400;

   // Sampler states, one-hot
   typedef enum logic [3:0] {
      FSU_ST_OFF = 4'h1,
      FSU_ST_COUNT = 4'h2,
      FSU_ST_PEND = 4'h4,
      FSU_ST_BUSY = 4'h8
   } fsu_state_e;
endpackage

// >>> hw/fsu_lat_if.sv
// Link between the sampler and its latency timer
`timescale 1ns/100ps
interface fsu_lat_if;
   logic start;
   logic stop;
   logic [fsu_pkg::FSU_LAT_W-1:0] count;
   modport ctl (output start, output stop, input count);
   modport tmr (input start, input stop, output count);
endinterface

// >>> hw/fsu_latency.sv
// Fetch latency timer, saturating at all ones
`timescale 1ns/100ps
module fsu_latency #(
   parameter int LAT_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Timer control
   fsu_lat_if.tmr lat
);
   import fsu_pkg::*;

   logic run_reg, run_next;
   logic [LAT_W-1:0] count_reg, count_next;

   // Elaboration check: the field width is fixed by the control word
   if (LAT_W != FSU_LAT_W) begin : g_bad_width
      $error("fsu_latency: LAT_W must match the latency field");
   end

   // Start loads one so the start edge itself counts; saturation keeps long misses from wrapping
   always_comb begin
      run_next = run_reg;
      count_next = count_reg;
      if (lat.start) begin
         run_next = 1'b1;
         count_next = LAT_W'(1);
      end else if (lat.stop) begin
         run_next = 1'b0;
      end else if (run_reg && count_reg != {LAT_W{1'b1}}) begin
         count_next = count_reg + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= 1'b0;
         count_reg <= '0;
      end else begin
         run_reg <= run_next;
         count_reg <= count_next;
      end
   end

   assign lat.count = count_reg;
endmodule

// >>> hw/fsu_lfsr.sv
// Free-running pseudo-random source for the counter low bits
`timescale 1ns/100ps
module fsu_lfsr #(
   parameter int LFSR_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Random nibble
   output logic [3:0] rand_nibble
);
   import fsu_pkg::*;

   logic [LFSR_W-1:0] lfsr_reg, lfsr_next;

   // Elaboration check: the tap set only serves one width
   if (LFSR_W != FSU_LFSR_W) begin : g_bad_width
      $error("fsu_lfsr: LFSR_W must match the tap set");
   end

   // Galois shift; the seed is nonzero so the sequence never locks
   always_comb begin
      lfsr_next = {1'b0, lfsr_reg[LFSR_W-1:1]};
      if (lfsr_reg[0]) lfsr_next = lfsr_next ^ FSU_LFSR_TAPS;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) lfsr_reg <= FSU_LFSR_SEED;
      else lfsr_reg <= lfsr_next;
   end

   assign rand_nibble = lfsr_reg[3:0];
endmodule

// >>> dv/fsu_fetch_model.sv
// Behavioural fetch pipeline that feeds the sampler's fetch event inputs
`timescale 1ns/100ps
module fsu_fetch_model (
   // Clock
   input wire logic clock,
   // Fetch events and status
   output logic fetch_start,
   output logic fetch_done,
   output logic fetch_abort,
   output logic fetch_icache_miss,
   output logic fetch_tlb_miss,
   output logic fetch_phys_ok,
   output logic [1:0] fetch_page_size,
   output logic [63:0] fetch_lin_addr,
   output logic [fsu_pkg::FSU_PHYS_W-1:0] fetch_phys_addr
);
   import fsu_pkg::*;

   // Quiet pipeline at time zero
   initial begin
      {fetch_start, fetch_done, fetch_abort, fetch_icache_miss, fetch_tlb_miss, fetch_phys_ok} = 6'h00;
      fetch_page_size = 2'h0;
      fetch_lin_addr = 64'h0;
      fetch_phys_addr = '0;
   end

   // One fetch: start, lt cycles in flight, then done or abort with status
   task automatic run(input int lt, input logic ab, input logic [2:0] st, input logic [1:0] pg,
                      input logic [63:0] lin, input logic [FSU_PHYS_W-1:0] phys);
      @(posedge clock);
      fetch_start <= 1'b1;
      @(posedge clock);
      fetch_start <= 1'b0;
      repeat (lt - 1) @(posedge clock);
      fetch_done <= !ab;
      fetch_abort <= ab;
      {fetch_phys_ok, fetch_tlb_miss, fetch_icache_miss} <= st;
      fetch_page_size <= pg;
      fetch_lin_addr <= lin;
      fetch_phys_addr <= phys;
      @(posedge clock);
      fetch_done <= 1'b0;
      fetch_abort <= 1'b0;
      // Status is not held past its sampling edge, so show the inverse
      {fetch_phys_ok, fetch_tlb_miss, fetch_icache_miss} <= ~st;
      fetch_page_size <= ~pg;
      fetch_lin_addr <= ~lin;
      fetch_phys_addr <= ~phys;
   endtask
endmodule

// >>> dv/fsu_top_tb.sv
// Self-checking bench for the fetch sampling unit
`timescale 1ns/100ps
module fsu_top_tb;
   import fsu_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] reg_sel = 2'h0;
   logic [63:0] reg_wdata = 64'h0;
   logic [63:0] reg_rdata, rd_val, lin;
   logic reg_rvalid, tag_request, sample_irq;
   logic f_start, f_done, f_abort, f_icm, f_tlbm, f_pok;
   logic [1:0] f_pg;
   logic [63:0] f_lin;
   logic [FSU_PHYS_W-1:0] f_phys, phys;
   logic [63:0] exp_q[$];
   int err_total = 0;
   int num_checks = 0;
   int seed = 32'h6689EE79;
   int c, d, n, lat;

   fsu_top dut_u (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fetch_start(f_start),
      .fetch_done(f_done), .fetch_abort(f_abort), .fetch_icache_miss(f_icm), .fetch_tlb_miss(f_tlbm),
      .fetch_phys_ok(f_pok), .fetch_page_size(f_pg), .fetch_lin_addr(f_lin), .fetch_phys_addr(f_phys),
      .tag_request(tag_request), .sample_irq(sample_irq));

   fsu_fetch_model fm_u (.clock(clock), .fetch_start(f_start), .fetch_done(f_done), .fetch_abort(f_abort),
      .fetch_icache_miss(f_icm), .fetch_tlb_miss(f_tlbm), .fetch_phys_ok(f_pok), .fetch_page_size(f_pg),
      .fetch_lin_addr(f_lin), .fetch_phys_addr(f_phys));

   // 20 MHz core clock
   always #25 clock = ~clock;

   // Compare and count
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Expected control word from model fields
   function automatic logic [63:0] ctl(input int rnd, tl, pg, pv, ic, cp, vl, en, lt, cn, mx);
      return {6'h00, 1'(rnd), 1'b0, 1'(tl), 2'(pg), 1'(pv), 1'(ic), 1'(cp), 1'(vl), 1'(en),
              16'(lt), 16'(cn), 16'(mx)};
   endfunction

   // Control write, one-cycle strobe
   task automatic wr(input logic [63:0] w);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_sel <= FSU_SEL_CTRL;
      reg_wdata <= w;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read; answer comes one cycle after the strobe
   task automatic rd(input logic [1:0] s);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_sel <= s;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rvalid, 1'b1);
      rd_val = reg_rdata;
   endtask

   // Fetch with fresh random addresses
   task automatic fetch(input int lt, input logic ab, input logic [2:0] st, input logic [1:0] pg);
      lin = {$random(seed), $random(seed)};
      phys = FSU_PHYS_W'({$random(seed), $random(seed)});
      fm_u.run(lt, ab, st, pg, lin, phys);
   endtask

   // Bounded wait for the tag level
   task automatic wait_tag(input logic v);
      #1;
      for (int k = 0; k < 4 && tag_request !== v; k++) begin
         @(posedge clock);
         #1;
      end
      chk(tag_request, v);
   endtask

   // Counts, verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog, far beyond the expected few hundred cycles
   initial begin
      #(50 * 8000);
      err_total++;
      results();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(FSU_SEL_CTRL);
      chk(rd_val, 64'h0);
      rd(2'h3);
      chk(rd_val, 64'h0);
      // Reserved bits set, sampling off: fetches must not count
      wr(64'hFD00_0000_0003_0005);
      // A write to a read-only select must not land
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_sel <= FSU_SEL_LIN;
      reg_wdata <= 64'h0001_0000_0000_0000;
      @(posedge clock);
      reg_wr <= 1'b0;
      fetch(1, 1'b0, 3'($random(seed)), 2'($random(seed)));
      rd(FSU_SEL_CTRL);
      chk(rd_val, 64'h0000_0000_0003_0005);
      chk(tag_request, 1'b0);
      // Armed runs: immediate match, one step, two steps, and an abort
      for (int i = 0; i < 4; i++) begin
         c = $random(seed) & 16'h3FFF;
         d = (i == 0) ? 0 : (i == 2) ? 2 : 1;
         wr(ctl(0, 0, 0, 0, 0, 0, 0, 1, 0, c, c + d));
         repeat (2) @(posedge clock);
         for (n = 0; n < d * 16; n++) begin
            if (n == 16) begin
               rd(FSU_SEL_CTRL);
               chk(rd_val[31:16], 16'(c + 1));
            end
            if (n == d * 16 - 1) chk(tag_request, 1'b0);
            fetch(1, 1'b0, 3'($random(seed)), 2'($random(seed)));
         end
         wait_tag(1'b1);
         lat = 1 + 3 * i;
         fetch(lat, i == 3, {i != 2, 2'(i)}, 2'(i));
         exp_q.push_back(lin);
         exp_q.push_back({12'h000, phys});
         #1;
         chk(sample_irq, 1'b1);
         chk(tag_request, 1'b0);
         // Save everything before any re-arm
         rd(FSU_SEL_CTRL);
         chk(rd_val, ctl(0, i / 2, (i != 2) ? i : 0, i != 2, i % 2, i != 3, 1, 1, lat, c + d, c + d));
         rd(FSU_SEL_LIN);
         chk(rd_val, exp_q.pop_front());
         rd(FSU_SEL_PHYS);
         if (i != 2) chk(rd_val, exp_q[0]);
         exp_q.delete();
         // Counter stays halted while the sample is valid
         fetch(1, 1'b0, 3'($random(seed)), 2'($random(seed)));
         rd(FSU_SEL_CTRL);
         chk(rd_val[31:16], 16'(c + d));
      end
      // Randomized low bits: one step needs between 1 and 16 fetches
      c = $random(seed) & 16'h3FFF;
      wr(ctl(1, 0, 0, 0, 0, 0, 0, 1, 0, c, c + 1));
      repeat (2) @(posedge clock);
      for (n = 0; n < 17 && tag_request !== 1'b1; n++) begin
         fetch(1, 1'b0, 3'($random(seed)), 2'($random(seed)));
         repeat (2) @(posedge clock);
         #1;
      end
      chk(64'(n >= 1 && n <= 16), 64'h1);
      rd(FSU_SEL_CTRL);
      chk(rd_val[57], 1'b1);
      // Disabling cancels the pending tag
      wr(ctl(0, 0, 0, 0, 0, 0, 0, 0, 0, c, c + 1));
      wait_tag(1'b0);
      results();
   end
endmodule
